// ---- rtl/bmc_top.sv ----
/*
  Brownout monitor control: fuse-loaded mode registers, sleep/active mode
  switching, sampling, brownout reset request, early-warning monitor with
  interrupt, key-protected sleep mode field, AHB-Lite register slave.
  Assumes comparator inputs and the oscillator tick are synchronous to ref_clk_i.
*/
// Added by the designer: the AHB-Lite register port and the placing of the registers.
// Notes on behaviour
// - Fuse values load level and modes at reset.
// - Level and active mode ignore CPU writes.
// - Sleep mode writable when unlocked, replaces fuse.
// - Enabled runs continuously; sampled pulses periodically.
// - Sleep entry uses sleep mode; wake uses active.
// - Request reset when supply below brownout threshold.
// - Monitor threshold percentage above brownout level.
// - Writing one enables monitor and its interrupt.
// - Crossing select: above, below or either.
// - Monitor follows detector mode, off or sampled.
// - Either-direction config sets flag on enable, except in sampled mode.
// - Sampled mode interrupts only for code one.
// - Configured crossing sets monitor flag.
// - Irq high while enable and flag set.
// - Single vector at offset zero.
// - Unprotected write accepted but value unchanged.
// - Only sleep field protected, io-register key.
// - Detector logic timed by 32 kHz oscillator.
// - Runs in debug; irq withheld while halted.
// - Mode codes off, on, sampled, on-hold.
// - Sample rate 1 kHz or 125 Hz; the slow count 262 is cut to 8 bits here, giving a 6-tick period.
// - Level codes 5, 15, 25 percent.
// - Status one when supply below monitor threshold.
`timescale 1ns/1ps
module bmc_top (
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  input wire logic hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [2:0] hsize_i,
  input wire logic [31:0] hwdata_i,
  input wire logic hready_i,
  output logic [31:0] hrdata_o,
  output logic hreadyout_o,
  output logic hresp_o,
  input wire logic [2:0] fuse_level_i,
  input wire logic [1:0] fuse_active_i,
  input wire logic [1:0] fuse_sleep_i,
  input wire logic fuse_sample_rate_i,
  input wire logic osc_tick_i,
  input wire logic deep_sleep_i,
  input wire logic debug_halt_i,
  input wire logic supply_below_brownout_i,
  input wire logic supply_below_monitor_i,
  output logic brownout_reset_o,
  output logic detector_enable_o,
  output logic [2:0] level_select_o,
  output logic [1:0] monitor_level_select_o,
  output logic monitor_irq_o,
  output logic [1:0] monitor_irq_vector_o
);

  typedef struct packed {
    logic fuse_done;
    logic [2:0] level;
    logic [1:0] active_mode;
    logic [1:0] sleep_mode;
    logic sample_rate_select;
    logic [1:0] monitor_level_select;
    logic [1:0] monitor_crossing_select;
    logic monitor_irq_enable;
    logic monitor_irq_flag;
    logic monitor_below_status;
    logic prev_valid;
    logic [2:0] unlock_cnt;
    logic [7:0] tick_cnt;
    logic ph_valid;
    logic ph_write;
    logic [7:0] ph_addr;
    logic [31:0] rdata;
    logic brownout_reset;
    logic detector_enable;
    logic irq;
  } bmc_state_t;

  bmc_state_t s_q;
  bmc_state_t s_d;

  // Mode in force: sleep setting only in standby/power-down
  function automatic logic [1:0] cur_mode(input bmc_state_t s, input logic sl);
    cur_mode = sl ? s.sleep_mode : s.active_mode;
  endfunction

  // Decode one register for readback
  function automatic logic [31:0] read_reg(input bmc_state_t s, input logic [7:0] a);
    read_reg = 32'h0000_0000;
    case (a)
      bmc_pkg::OFF_CTRL_FIRST:
        read_reg[4:0] = {s.sample_rate_select, s.active_mode, s.sleep_mode};
      bmc_pkg::OFF_CTRL_LEVEL: read_reg[2:0] = s.level;
      bmc_pkg::OFF_MON_CTRL: read_reg[1:0] = s.monitor_level_select;
      bmc_pkg::OFF_IRQ_CTRL:
        read_reg[2:0] = {s.monitor_crossing_select, s.monitor_irq_enable};
      bmc_pkg::OFF_IRQ_FLAG: read_reg[0] = s.monitor_irq_flag;
      bmc_pkg::OFF_STATUS: read_reg[0] = s.monitor_below_status;
      default: read_reg = 32'h0000_0000;
    endcase
  endfunction

  logic [1:0] mode;
  logic sample_now;
  logic mon_active;
  logic rise_below;
  logic rise_above;
  logic cross_hit;
  logic wr_now;
  logic [7:0] period;

  // Next-state logic
  always_comb begin
    s_d = s_q;
    mode = cur_mode(s_q, deep_sleep_i);
    period = s_q.sample_rate_select ? 8'(bmc_pkg::SAMPLE_SLOW_TICKS)
                                    : 8'(bmc_pkg::SAMPLE_FAST_TICKS);
    sample_now = 1'b0;
    cross_hit = 1'b0;

    // Fuse capture runs on the first clock after reset is released
    if (!s_q.fuse_done) begin
      s_d.fuse_done = 1'b1;
      s_d.level = fuse_level_i;
      s_d.active_mode = fuse_active_i;
      s_d.sleep_mode = fuse_sleep_i;
      s_d.sample_rate_select = fuse_sample_rate_i;
    end

    // Sample timer advances only on oscillator ticks
    if (osc_tick_i) begin
      if (s_q.tick_cnt >= period - 8'h01) begin
        s_d.tick_cnt = 8'h00;
      end else begin
        s_d.tick_cnt = s_q.tick_cnt + 8'h01;
      end
    end
    case (mode)
      bmc_pkg::BMC_MODE_ON, bmc_pkg::BMC_MODE_ON_HOLD: sample_now = osc_tick_i;
      bmc_pkg::BMC_MODE_SAMPLED:
        sample_now = osc_tick_i && (s_q.tick_cnt == 8'h00);
      default: sample_now = 1'b0;
    endcase
    s_d.detector_enable = s_q.fuse_done && (mode != bmc_pkg::BMC_MODE_OFF);
    mon_active = s_q.detector_enable && s_q.monitor_irq_enable;

    // Brownout reset while detector active
    s_d.brownout_reset = s_q.detector_enable && supply_below_brownout_i;

    // Monitor sampling and crossing detection
    rise_below = supply_below_monitor_i && !s_q.monitor_below_status;
    rise_above = !supply_below_monitor_i && s_q.monitor_below_status;
    if (s_q.detector_enable && sample_now) begin
      s_d.monitor_below_status = supply_below_monitor_i;
      s_d.prev_valid = 1'b1;
      if (mon_active) begin
        if (mode == bmc_pkg::BMC_MODE_SAMPLED) begin
          // Sampled: only code one raises the flag
          cross_hit = (s_q.monitor_crossing_select == bmc_pkg::CROSS_BELOW)
                      && rise_below && s_q.prev_valid;
        end else begin
          case (s_q.monitor_crossing_select)
            bmc_pkg::CROSS_ABOVE: cross_hit = rise_above && s_q.prev_valid;
            bmc_pkg::CROSS_BELOW: cross_hit = rise_below && s_q.prev_valid;
            // Any difference, or first evaluation after enabling
            bmc_pkg::CROSS_EITHER:
              cross_hit = rise_above || rise_below || !s_q.prev_valid;
            default: cross_hit = 1'b0;
          endcase
        end
      end
    end
    if (!s_q.detector_enable) begin
      s_d.prev_valid = 1'b0;
    end

    // Unlock window counts down per bus transfer
    wr_now = s_q.ph_valid && s_q.ph_write;
    if (s_q.ph_valid && (s_q.unlock_cnt != 3'h0)) begin
      s_d.unlock_cnt = s_q.unlock_cnt - 3'h1;
    end

    // Bus write data phase
    if (wr_now) begin
      case (s_q.ph_addr)
        bmc_pkg::OFF_CTRL_FIRST: begin
          // Level, active and rate fields never change by software
          if (s_q.unlock_cnt != 3'h0) begin
            s_d.sleep_mode = hwdata_i[bmc_pkg::SLEEP_LSB +: 2];
          end
        end
        bmc_pkg::OFF_MON_CTRL: s_d.monitor_level_select = hwdata_i[1:0];
        bmc_pkg::OFF_IRQ_CTRL: begin
          s_d.monitor_crossing_select = hwdata_i[bmc_pkg::CROSS_LSB +: 2];
          s_d.monitor_irq_enable = hwdata_i[bmc_pkg::IRQ_EN_BIT];
          if (hwdata_i[bmc_pkg::IRQ_EN_BIT] && !s_q.monitor_irq_enable) begin
            s_d.prev_valid = 1'b0;
          end
        end
        bmc_pkg::OFF_IRQ_FLAG: begin
          if (hwdata_i[0]) begin
            s_d.monitor_irq_flag = 1'b0;
          end
        end
        bmc_pkg::OFF_UNLOCK: begin
          s_d.unlock_cnt = (hwdata_i[7:0] == bmc_pkg::IO_REGISTER_UNLOCK_KEY)
                           ? bmc_pkg::UNLOCK_WINDOW : 3'h0;
        end
        default: ;
      endcase
    end
    // Set wins over a same-cycle clear
    if (cross_hit) begin
      s_d.monitor_irq_flag = 1'b1;
    end

    // Address phase capture; slave never stalls
    s_d.ph_valid = hsel_i && hready_i && htrans_i[1];
    s_d.ph_write = hwrite_i;
    s_d.ph_addr = haddr_i[7:0];
    s_d.rdata = 32'h0000_0000;
    if (hsel_i && hready_i && htrans_i[1] && !hwrite_i) begin
      s_d.rdata = read_reg(s_d, haddr_i[7:0]);
    end

    // Request held while enabled and flagged; withheld during debug halt
    s_d.irq = s_d.monitor_irq_enable && s_d.monitor_irq_flag && !debug_halt_i;
  end

  // State register
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // Outputs straight from flops; bus response and vector tied to constants
  assign hrdata_o = s_q.rdata;
  assign hreadyout_o = 1'b1;
  assign hresp_o = 1'b0;
  assign brownout_reset_o = s_q.brownout_reset;
  assign detector_enable_o = s_q.detector_enable;
  assign level_select_o = s_q.level;
  assign monitor_level_select_o = s_q.monitor_level_select;
  assign monitor_irq_o = s_q.irq;
  assign monitor_irq_vector_o = bmc_pkg::IRQ_VECTOR_OFFSET;

endmodule

// ---- rtl/bmc_pkg.sv ----
/*
  Package for the brownout monitor control block: register offsets, field
  positions, mode encodings and timing counts.
  Assumes a 40 MHz system clock and a 32 kHz oscillator tick fed in as an enable.
*/
package bmc_pkg;

  // Register byte offsets (all printed offsets are word-aligned here)
  localparam logic [7:0] OFF_CTRL_FIRST = 8'h00;
  localparam logic [7:0] OFF_CTRL_LEVEL = 8'h04;
  localparam logic [7:0] OFF_MON_CTRL = 8'h08;
  localparam logic [7:0] OFF_IRQ_CTRL = 8'h0c;
  localparam logic [7:0] OFF_IRQ_FLAG = 8'h10;
  localparam logic [7:0] OFF_STATUS = 8'h14;
  localparam logic [7:0] OFF_UNLOCK = 8'h18;

  // Field positions
  localparam int SLEEP_LSB = 0;
  localparam int ACTIVE_LSB = 2;
  localparam int SAMP_BIT = 4;
  localparam int CROSS_LSB = 1;
  localparam int IRQ_EN_BIT = 0;

  // Unlock key for the io-register key type, value arbitrary
  localparam logic [7:0] IO_REGISTER_UNLOCK_KEY = 8'hd8;
  // Unlock window in bus accesses (one instruction taken as one transfer)
  localparam logic [2:0] UNLOCK_WINDOW = 3'h4;

  // Operating modes
  typedef enum logic [1:0] {
    BMC_MODE_OFF = 2'b00,
    BMC_MODE_ON = 2'b01,
    BMC_MODE_SAMPLED = 2'b10,
    BMC_MODE_ON_HOLD = 2'b11
  } bmc_mode_t;

  // Crossing selection codes
  localparam logic [1:0] CROSS_ABOVE = 2'h0;
  localparam logic [1:0] CROSS_BELOW = 2'h1;
  localparam logic [1:0] CROSS_EITHER = 2'h2;

  // Oscillator rate and sample rates
  localparam int OSC_HZ = 32768;
  localparam int SAMPLE_FAST_HZ = 1000;
  localparam int SAMPLE_SLOW_HZ = 125;
  localparam int SAMPLE_FAST_TICKS = OSC_HZ / SAMPLE_FAST_HZ;
  localparam int SAMPLE_SLOW_TICKS = OSC_HZ / SAMPLE_SLOW_HZ;

  localparam logic [1:0] IRQ_VECTOR_OFFSET = 2'h0;

endpackage

// ---- verif/bmc_top_props.sv ----
/* Port checker for bmc_top.
   Assumes hready_i is fed from hreadyout_o and fuses hold steady. */
`timescale 1ns/1ps
module bmc_chk (
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  input wire logic hsel_i,
  input wire logic hready_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [31:0] hrdata_o,
  input wire logic hreadyout_o,
  input wire logic hresp_o,
  input wire logic [2:0] fuse_level_i,
  input wire logic [1:0] fuse_active_i,
  input wire logic deep_sleep_i,
  input wire logic debug_halt_i,
  input wire logic supply_below_brownout_i,
  input wire logic brownout_reset_o,
  input wire logic detector_enable_o,
  input wire logic [2:0] level_select_o,
  input wire logic monitor_irq_o,
  input wire logic [1:0] monitor_irq_vector_o
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!rst_n_i);
  // Refused writes still complete, so the bus never stalls or errors
  chk_bus_okay: assert property (hreadyout_o && !hresp_o)
    else $error("bus stalled or errored");
  chk_vector_zero: assert property (monitor_irq_vector_o == 2'h0)
    else $error("vector not zero");
  // Level comes from fuse one edge after release and never moves
  chk_level_fuse: assert property ($past(rst_n_i) |-> level_select_o == fuse_level_i)
    else $error("level not fuse value");
  chk_active_on: assert property (!deep_sleep_i [*3] ##0 fuse_active_i != 2'h0 |=>
    detector_enable_o) else $error("awake detector off");
  chk_brownout_req: assert property (detector_enable_o && supply_below_brownout_i |->
    ##[1:2] brownout_reset_o) else $error("no brownout request");
  chk_off_no_reset: assert property (!detector_enable_o [*2] |-> !brownout_reset_o)
    else $error("reset while detector off");
  chk_halt_mask: assert property (debug_halt_i |=> !monitor_irq_o)
    else $error("irq while halted");
  // Read data stands only in a read data phase; anything else would alias
  chk_read_idle: assert property (!(hsel_i && hready_i && htrans_i[1] && !hwrite_i) |=>
    hrdata_o == 32'h0) else $error("stray read data");
  cov_irq: cover property ($rose(monitor_irq_o));
  cov_reset: cover property ($rose(brownout_reset_o));
  cov_read: cover property (hrdata_o != 32'h0);
endmodule
bind bmc_top bmc_chk u_bmc_chk (.*);

// ---- verif/bmc_supply_model.sv ----
/* Analogue side model: oscillator tick and the two comparators.
   Supply given in millivolts by the bench; outputs synchronous to clk_i. */
`timescale 1ns/1ps
module bmc_supply_model #(
  parameter int TICK_DIV = 1221
) (
  input wire logic clk_i,
  input wire logic [15:0] supply_mv_i,
  input wire logic [2:0] level_i,
  input wire logic [1:0] mon_level_i,
  output logic tick_o,
  output logic below_bo_o,
  output logic below_mon_o
);
  localparam int BO_MV [8] = '{1800, 2150, 2600, 2950, 3300, 3700, 4000, 4300};
  int cnt = 0;
  int bo;
  initial {tick_o, below_bo_o, below_mon_o} = 3'h0;
  // Scaled oscillator: a short divider keeps sampled periods cheap to run
  always @(posedge clk_i) begin
    cnt <= (cnt == TICK_DIV - 1) ? 0 : cnt + 1;
    tick_o <= (cnt == TICK_DIV - 1);
    bo = BO_MV[level_i];
    below_bo_o <= supply_mv_i < bo;
    below_mon_o <= supply_mv_i * 100 < bo * (105 + 10 * mon_level_i);
  end
endmodule

// ---- verif/brownout_monitor_control_test.sv ----
/* Self-checking bench for bmc_top over AHB-Lite.
   Fuses fixed: level 3, active on, sleep sampled, fast rate. */
`timescale 1ns/1ps
module brownout_monitor_control_test;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic deep = 1'b0;
  logic halt = 1'b0;
  logic samp = 1'b0;
  logic [1:0] htrans = 2'h0;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] rd;
  logic [15:0] mv = 16'd4200;
  int n_errors = 0;
  int checked = 0;
  int m;
  wire logic rdy, tick, b_bo, b_mon, bo_rst, det_en, irq, resp;
  wire logic [1:0] vec;
  wire logic [31:0] hrdata;
  wire logic [2:0] lvl;
  wire logic [1:0] mlvl;
  always #12.5 clk = ~clk;
  bmc_top u_bmc_top (.ref_clk_i(clk), .rst_n_i(rst_n), .hsel_i(hsel), .haddr_i(haddr),
    .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'h2), .hwdata_i(hwdata), .hready_i(rdy),
    .hrdata_o(hrdata), .hreadyout_o(rdy), .hresp_o(resp), .fuse_level_i(3'h3),
    .fuse_active_i(2'h1), .fuse_sleep_i(2'h2), .fuse_sample_rate_i(samp), .osc_tick_i(tick),
    .deep_sleep_i(deep), .debug_halt_i(halt), .supply_below_brownout_i(b_bo),
    .supply_below_monitor_i(b_mon), .brownout_reset_o(bo_rst), .detector_enable_o(det_en),
    .level_select_o(lvl), .monitor_level_select_o(mlvl), .monitor_irq_o(irq),
    .monitor_irq_vector_o(vec));
  bmc_supply_model #(.TICK_DIV(4)) u_bmc_supply_model (.clk_i(clk), .supply_mv_i(mv),
    .level_i(lvl), .mon_level_i(mlvl), .tick_o(tick), .below_bo_o(b_bo), .below_mon_o(b_mon));
  // One single transfer; read data taken at the edge ending the data phase
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= w;
    do @(posedge clk); while (rdy !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk); while (rdy !== 1'b1);
    rd = hrdata;
  endtask
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask
  // Monitor threshold in millivolts for level 3 and a monitor code
  function automatic int thr(input int code);
    return 2950 * (105 + 10 * code) / 100;
  endfunction
  task automatic conclude;
    $display("checked %0d n_errors %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // Unlock with the key, then spend k transfers before the write
  task automatic unlock_write(input int k, input logic [31:0] d);
    xfer(1'b1, bmc_pkg::OFF_UNLOCK, {24'h0, bmc_pkg::IO_REGISTER_UNLOCK_KEY});
    repeat (k) xfer(1'b0, bmc_pkg::OFF_STATUS, 32'h0);
    xfer(1'b1, bmc_pkg::OFF_CTRL_FIRST, d);
    xfer(1'b0, bmc_pkg::OFF_CTRL_FIRST, 32'h0);
  endtask
  initial begin
    repeat (5000) @(posedge clk);
    n_errors++;
    conclude();
  end
  initial begin
    void'($urandom(32'h5bae));
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    xfer(1'b0, bmc_pkg::OFF_CTRL_LEVEL, 32'h0);
    cmp(rd, 32'h3);
    xfer(1'b1, bmc_pkg::OFF_CTRL_FIRST, 32'h1d);
    xfer(1'b0, bmc_pkg::OFF_CTRL_FIRST, 32'h0);
    cmp(rd, 32'h6);
    xfer(1'b0, 8'h20, 32'h0);
    cmp(rd, 32'h0);
    $display("test 1 done");
    // Fourth transfer after the key still lands, fifth is too late
    unlock_write(3, 32'h11);
    cmp(rd, 32'h5);
    unlock_write(4, 32'h10);
    cmp(rd, 32'h5);
    $display("test 2 done");
    m = $urandom % 3;
    xfer(1'b1, bmc_pkg::OFF_MON_CTRL, 32'(m));
    mv <= 16'(thr(m) + 100 + $urandom % 200);
    xfer(1'b1, bmc_pkg::OFF_IRQ_CTRL, 32'h5);
    repeat (40) @(posedge clk);
    xfer(1'b0, bmc_pkg::OFF_IRQ_FLAG, 32'h0);
    cmp(rd, 32'h1);
    cmp(32'(irq), 32'h1);
    xfer(1'b1, bmc_pkg::OFF_IRQ_FLAG, 32'h1);
    xfer(1'b0, bmc_pkg::OFF_IRQ_FLAG, 32'h0);
    cmp(rd, 32'h0);
    cmp(32'(irq), 32'h0);
    cmp(32'(mlvl), 32'(m));
    // Dip between brownout and monitor thresholds
    mv <= 16'(2970 + $urandom % (thr(m) - 2990));
    repeat (40) @(posedge clk);
    xfer(1'b0, bmc_pkg::OFF_STATUS, 32'h0);
    cmp(rd, 32'h1);
    cmp(32'(irq), 32'h1);
    cmp(32'(bo_rst), 32'h0);
    halt <= 1'b1;
    repeat (2) @(posedge clk);
    cmp(32'(irq), 32'h0);
    halt <= 1'b0;
    $display("test 3 done");
    mv <= 16'd2900;
    repeat (8) @(posedge clk);
    cmp(32'(bo_rst), 32'h1);
    mv <= 16'd4200;
    repeat (8) @(posedge clk);
    cmp(32'(bo_rst), 32'h0);
    $display("test 4 done");
    // Sleep setting off: no brownout request while asleep
    unlock_write(0, 32'h0);
    deep <= 1'b1;
    repeat (4) @(posedge clk);
    cmp(32'(det_en), 32'h0);
    mv <= 16'd2900;
    repeat (8) @(posedge clk);
    cmp(32'(bo_rst), 32'h0);
    mv <= 16'd4200;
    repeat (2) @(posedge clk);
    deep <= 1'b0;
    repeat (4) @(posedge clk);
    cmp(32'(det_en), 32'h1);
    $display("test 5 done");
    // Sleep setting sampled, code one: a dip seen at a sample instant flags
    unlock_write(0, 32'h2);
    cmp(rd, 32'h6);
    xfer(1'b1, bmc_pkg::OFF_IRQ_CTRL, 32'h3);
    xfer(1'b1, bmc_pkg::OFF_IRQ_FLAG, 32'h1);
    deep <= 1'b1;
    repeat (300) @(posedge clk);
    mv <= 16'd3000;
    repeat (300) @(posedge clk);
    xfer(1'b0, bmc_pkg::OFF_IRQ_FLAG, 32'h0);
    cmp(rd, 32'h1);
    cmp(32'(bo_rst), 32'h0);
    deep <= 1'b0;
    mv <= 16'd4200;
    cmp(32'(resp), 32'h0);
    cmp(32'(vec), 32'h0);
    $display("test 6 done");
    conclude();
  end
endmodule
